// file: testbench/ebus_reservation_gating_tb_top.sv
// Self-checking bench for both ends of the reservation link
`timescale 1ns/100ps
`default_nettype none
`include "erg_defs.svh"
`define ERG_CHK(got, exp, msg) \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
        fail_count++; \
        $display("mismatch at %0t: %s", $time, msg); \
    end
module ebus_reservation_gating_tb_top;
    localparam logic [`ERG_ADDR_W-1:0] A = 32'h0000_1230;
    localparam logic [2:0] LR = 3'b001;
    localparam logic [2:0] SC = 3'b110;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [`ERG_ADDR_W-1:0] req_addr_i = '0;
    logic req_write_i = 1'b0;
    logic req_store_cond_i = 1'b0;
    logic req_load_res_i = 1'b0;
    logic cr_port_mode_i = 1'b0;
    logic other_store_i = 1'b0;
    logic [`ERG_ADDR_W-1:0] other_addr_i = '0;
    logic remote_lost_i = 1'b0;
    logic remote_ready_i = 1'b1;
    logic req_ready_o, done_o, sc_success_o, mem_write_o;
    logic [`ERG_ADDR_W-1:0] mem_addr_o, last_addr;
    int fail_count = 0;
    int num_checks = 0;
    int ts_cnt = 0;
    int wr_cnt = 0;
    int cyc = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    erg_link_if erg_link_if_inst ();
    erg_device erg_device_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(erg_link_if_inst),
        .req_valid_i(req_valid_i), .req_addr_i(req_addr_i), .req_write_i(req_write_i),
        .req_store_cond_i(req_store_cond_i), .req_load_res_i(req_load_res_i),
        .cr_port_mode_i(cr_port_mode_i), .req_ready_o(req_ready_o), .done_o(done_o),
        .sc_success_o(sc_success_o));
    erg_snoop erg_snoop_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(erg_link_if_inst),
        .other_store_i(other_store_i), .other_addr_i(other_addr_i),
        .remote_lost_i(remote_lost_i), .remote_ready_i(remote_ready_i),
        .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o));
    erg_link_sva erg_link_sva_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .cr_port_mode_i(cr_port_mode_i), .bus_request_n(erg_link_if_inst.bus_request_n),
        .bus_grant_n(erg_link_if_inst.bus_grant_n),
        .transfer_start_n(erg_link_if_inst.transfer_start_n),
        .store_cond(erg_link_if_inst.store_cond), .address_ack_n(erg_link_if_inst.address_ack_n),
        .address_retry_n(erg_link_if_inst.address_retry_n),
        .cancel_reservation_n(erg_link_if_inst.cancel_reservation_n),
        .write_commit(erg_link_if_inst.write_commit));
    // Count bus starts and memory writes; a hang ends the run
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (!rst_i && erg_link_if_inst.transfer_start_n === 1'b0) ts_cnt++;
        if (mem_write_o === 1'b1)
        begin
            wr_cnt++;
            last_addr = mem_addr_o;
        end
        if (cyc == 3000)
        begin
            fail_count++;
            stop_test();
        end
    end
    // ---------------
    // Access tasks
    // ---------------
    // One request, then start count, write count and flag are compared
    task automatic op(input logic [31:0] a, input logic [2:0] k, input logic ok, input int dt,
        input int dw);
        int n;
        int t0;
        int w0;
        n = 0;
        @(negedge ref_clk_i);
        while (req_ready_o !== 1'b1 && n < 50)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        t0 = ts_cnt;
        w0 = wr_cnt;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_addr_i <= a;
        {req_write_i, req_store_cond_i, req_load_res_i} <= k;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        @(negedge ref_clk_i);
        while (done_o !== 1'b1 && n < 60)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        `ERG_CHK(done_o, 1'b1, "done pulse")
        `ERG_CHK(sc_success_o, ok, "success flag")
        repeat (3) @(negedge ref_clk_i);
        `ERG_CHK(ts_cnt - t0 == dt, 1'b1, "start count")
        if (dw >= 0)
        begin
            `ERG_CHK(wr_cnt - w0 == dw, 1'b1, "write count")
        end
        if (dw == 1)
        begin
            `ERG_CHK(last_addr, a, "write address")
        end
    endtask : op
    // Store by another master, one cycle
    task automatic other(input logic [31:0] a);
        @(posedge ref_clk_i);
        other_store_i <= 1'b1;
        other_addr_i <= a;
        @(posedge ref_clk_i);
        other_store_i <= 1'b0;
    endtask : other
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // ---------------
    // Test sequence
    // ---------------
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge ref_clk_i);
        `ERG_CHK(erg_link_if_inst.cancel_reservation_n, 1'b0, "idle reservation")
        op(A, SC, 1'b0, 0, 0);
        op(A, LR, 1'b0, 1, -1);
        `ERG_CHK(erg_link_if_inst.cancel_reservation_n, 1'b1, "reservation set")
        op(A, SC, 1'b1, 1, 1);
        op(A, SC, 1'b0, 0, 0);
        op(A, LR, 1'b0, 1, -1);
        other(A + 32'h2);
        op(A, SC, 1'b0, 0, 0);
        op(A, LR, 1'b0, 1, -1);
        other(A + 32'h4);
        op(A, SC, 1'b1, 1, 1);
        op(A, LR, 1'b0, 1, -1);
        op(A, 3'b100, 1'b0, 1, 1);
        op(A, 3'b000, 1'b0, 1, 0);
        op(A, SC, 1'b1, 1, 1);
        op(A, LR, 1'b0, 1, -1);
        @(posedge ref_clk_i);
        remote_ready_i <= 1'b0;
        fork
            op(A, SC, 1'b1, 1, 1);
            begin
                repeat (10) @(posedge ref_clk_i);
                remote_ready_i <= 1'b1;
            end
        join
        op(A, LR, 1'b0, 1, -1);
        @(posedge ref_clk_i);
        remote_lost_i <= 1'b1;
        op(A, SC, 1'b0, 1, 0);
        @(posedge ref_clk_i);
        remote_lost_i <= 1'b0;
        `ERG_CHK(erg_link_if_inst.cancel_reservation_n, 1'b0, "dropped after retry")
        @(posedge ref_clk_i);
        cr_port_mode_i <= 1'b1;
        // Pin ignored: the cycle runs, but the snoop end still refuses the write
        op(A, SC, 1'b1, 1, 0);
        stop_test();
    end
endmodule : ebus_reservation_gating_tb_top
`default_nettype wire

// file: testbench/erg_link_sva.sv
// Assertions watching the reservation gating link
`timescale 1ns/100ps
`default_nettype none
module erg_link_sva (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cr_port_mode_i,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic transfer_start_n,
    input wire logic store_cond,
    input wire logic address_ack_n,
    input wire logic address_retry_n,
    input wire logic cancel_reservation_n,
    input wire logic write_commit
);
    // ----------------
    // Link properties
    // ----------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Outside port mode a cancelled reservation must never reach the address phase
    chk_no_cancel_start: assert property (
        !transfer_start_n && store_cond && !cr_port_mode_i |-> $past(cancel_reservation_n, 2))
        else $error("store-cond started without reservation");
    chk_ts_after_grant: assert property (
        $fell(transfer_start_n) |-> !$past(bus_grant_n))
        else $error("start without grant");
    chk_ts_one_cycle: assert property (
        !transfer_start_n |=> transfer_start_n)
        else $error("start longer than one cycle");
    chk_grant_follows: assert property (
        $fell(bus_request_n) |=> !bus_grant_n)
        else $error("grant late");
    chk_answer_bound: assert property (
        $fell(transfer_start_n) |-> ##[1:20] (!address_ack_n || !address_retry_n))
        else $error("no ack or retry");
    chk_ack_retry_excl: assert property (
        !(!address_ack_n && !address_retry_n))
        else $error("ack and retry together");
    chk_retry_no_write: assert property (
        !address_retry_n |-> !write_commit ##1 !write_commit)
        else $error("write on retried cycle");
    chk_retry_drops_res: assert property (
        !address_retry_n |-> ##[1:2] !cancel_reservation_n)
        else $error("reservation kept after retry");
    chk_retry_regrant: assert property (
        !address_retry_n |-> ##[0:1] bus_grant_n)
        else $error("grant held through retry");
    // Main scenarios seen
    cover property (!address_retry_n);
    cover property (!address_ack_n && store_cond);
    cover property ($fell(transfer_start_n) && cr_port_mode_i);
endmodule : erg_link_sva
`default_nettype wire

// file: verilog/erg_defs.svh
// Shared constants for the reservation gating link
`ifndef ERG_DEFS_SVH
`define ERG_DEFS_SVH
`define ERG_ADDR_W 32
`define ERG_MASTERS 2
`define ERG_GRAN_LSB 2
`define ERG_RETRY_CYC 1
`endif

// file: verilog/erg_device.sv
// Device end: gates external store-conditional cycles on reservation state
//
// Notes on behaviour
// - Snoop logic watches every local access
// - One reservation entry per reserving master
// - Load-with-reservation sets entry and address
// - Other master store clears that reservation
// - Status valid before store-conditional address phase
// - Sample cancel first; asserted means no cycle
// - Negated cancel lets store-conditional run
// - After retry resample cancel and grant
// - Lost remote reservation: retry, drop status
// - Withhold store-conditional address ack until remote safe; plain stores are acked at once
// - Retried cycle never writes remote memory
// - Single master needs no tracking logic
// - Port mode treats reservation always valid (device end only; snoop end still refuses the write)
// - Cancel is per-CPU active-low level
// - On retry back off, repeat address
// - Own ordinary store keeps reservation
// - Lost reservation: store-conditional writes nothing
`timescale 1ns/100ps
`default_nettype none
`include "erg_defs.svh"
module erg_device #(
    parameter int ADDR_W = `ERG_ADDR_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    erg_link_if.device link,
    input wire logic req_valid_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_store_cond_i,
    input wire logic req_load_res_i,
    input wire logic cr_port_mode_i,
    output logic req_ready_o,
    output logic done_o,
    output logic sc_success_o
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W != `ERG_ADDR_W) begin : g_bad_width
        $error("erg_device: ADDR_W must match the link width");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Request fields held in flops for the whole bus cycle
    erg_pkg::erg_state_t state_ff, nxt_state;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic write_ff, nxt_write, sc_ff, nxt_sc, lr_ff, nxt_lr;
    logic breq_n_ff, nxt_breq_n, ts_n_ff, nxt_ts_n;
    logic ready_ff, nxt_ready, done_ff, nxt_done, succ_ff, nxt_succ;
    logic cr_ff, nxt_cr;
    logic cancelled;

    // Cancel matters only for store-conditional cycles
    // Port mode forces the reservation valid
    assign cancelled = sc_ff && !cr_port_mode_i && !cr_ff;

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    // Next-state logic for the bus sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_write = write_ff;
        nxt_sc = sc_ff;
        nxt_lr = lr_ff;
        nxt_breq_n = breq_n_ff;
        nxt_ts_n = 1'b1;
        nxt_ready = 1'b0;
        nxt_done = 1'b0;
        nxt_succ = 1'b0;
        nxt_cr = cr_ff;
        case (state_ff)
            erg_pkg::ERG_IDLE:
            begin
                // Ready is registered, so a take lands one cycle after it rises
                nxt_ready = 1'b1;
                if (req_valid_i && ready_ff)
                begin
                    nxt_ready = 1'b0;
                    nxt_addr = req_addr_i;
                    nxt_write = req_write_i;
                    nxt_sc = req_store_cond_i & req_write_i;
                    nxt_lr = req_load_res_i & ~req_write_i;
                    nxt_breq_n = 1'b0;
                    nxt_state = erg_pkg::ERG_ARB;
                end
            end
            erg_pkg::ERG_ARB:
            begin
                // Grant is looked at again after every retry
                // Cancel is a level; one registered sample decides the cycle
                if (!link.bus_grant_n)
                begin
                    nxt_cr = link.cancel_reservation_n;
                    nxt_state = erg_pkg::ERG_SAMPLE;
                end
            end
            erg_pkg::ERG_SAMPLE:
            begin
                if (cancelled)
                begin
                    // Abandon: nothing goes on the bus
                    nxt_breq_n = 1'b1;
                    nxt_done = 1'b1;
                    nxt_state = erg_pkg::ERG_DONE;
                end
                else
                begin
                    nxt_ts_n = 1'b0;
                    nxt_state = erg_pkg::ERG_ADDR;
                end
            end
            erg_pkg::ERG_ADDR:
            begin
                // Start lasts one cycle; the answer comes in WAIT
                nxt_state = erg_pkg::ERG_WAIT;
            end
            erg_pkg::ERG_WAIT:
            begin
                if (!link.address_retry_n)
                begin
                    // Back off and repeat the address phase
                    // Status may have dropped, so ARB samples it afresh
                    nxt_state = erg_pkg::ERG_ARB;
                end
                else if (!link.address_ack_n)
                begin
                    // Success only when a store-conditional got its ack
                    nxt_breq_n = 1'b1;
                    nxt_done = 1'b1;
                    nxt_succ = sc_ff;
                    nxt_state = erg_pkg::ERG_DONE;
                end
            end
            erg_pkg::ERG_DONE:
            begin
                // One quiet cycle keeps requests from overlapping
                nxt_state = erg_pkg::ERG_IDLE;
            end
            default:
            begin
                // Unused codes fall back to idle
                nxt_state = erg_pkg::ERG_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Registers of the sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= erg_pkg::ERG_IDLE;
            addr_ff <= '0;
            write_ff <= 1'b0;
            sc_ff <= 1'b0;
            lr_ff <= 1'b0;
            breq_n_ff <= 1'b1;
            ts_n_ff <= 1'b1;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            succ_ff <= 1'b0;
            cr_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            write_ff <= nxt_write;
            sc_ff <= nxt_sc;
            lr_ff <= nxt_lr;
            breq_n_ff <= nxt_breq_n;
            ts_n_ff <= nxt_ts_n;
            ready_ff <= nxt_ready;
            done_ff <= nxt_done;
            succ_ff <= nxt_succ;
            cr_ff <= nxt_cr;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Link and user outputs straight from flops
    assign link.bus_request_n = breq_n_ff;
    assign link.transfer_start_n = ts_n_ff;
    assign link.addr = addr_ff;
    assign link.write = write_ff;
    assign link.store_cond = sc_ff;
    assign link.load_res = lr_ff;
    assign req_ready_o = ready_ff;
    assign done_o = done_ff;
    assign sc_success_o = succ_ff;
endmodule : erg_device
`default_nettype wire

// file: verilog/erg_link_if.sv
// Interface joining the device end and the snoop end
`timescale 1ns/100ps
`default_nettype none
`include "erg_defs.svh"
interface erg_link_if;
    logic bus_request_n;
    logic bus_grant_n;
    logic transfer_start_n;
    logic [`ERG_ADDR_W-1:0] addr;
    logic write;
    logic store_cond;
    logic load_res;
    logic address_ack_n;
    logic address_retry_n;
    logic cancel_reservation_n;
    logic write_commit;
    modport device (
        output bus_request_n, transfer_start_n, addr, write, store_cond, load_res,
        input bus_grant_n, address_ack_n, address_retry_n, cancel_reservation_n,
        input write_commit
    );
    modport snoop (
        input bus_request_n, transfer_start_n, addr, write, store_cond, load_res,
        output bus_grant_n, address_ack_n, address_retry_n, cancel_reservation_n,
        output write_commit
    );
endinterface : erg_link_if
`default_nettype wire

// file: verilog/erg_pkg.sv
// Types used by the device end of the reservation gating link
`default_nettype none
package erg_pkg;
    typedef enum logic [2:0] {
        ERG_IDLE = 3'b000,
        ERG_ARB = 3'b001,
        ERG_SAMPLE = 3'b011,
        ERG_ADDR = 3'b010,
        ERG_WAIT = 3'b110,
        ERG_DONE = 3'b111
    } erg_state_t;
endpackage : erg_pkg
`default_nettype wire

// file: verilog/erg_snoop.sv
// Snoop end: reservation tracking and non-local interface for one master
`timescale 1ns/100ps
`default_nettype none
`include "erg_defs.svh"
module erg_snoop #(
    parameter int ADDR_W = `ERG_ADDR_W,
    parameter int GRAN_LSB = `ERG_GRAN_LSB
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    erg_link_if.snoop link,
    input wire logic other_store_i,
    input wire logic [ADDR_W-1:0] other_addr_i,
    input wire logic remote_lost_i,
    input wire logic remote_ready_i,
    output logic mem_write_o,
    output logic [ADDR_W-1:0] mem_addr_o
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (GRAN_LSB < 2 || GRAN_LSB >= ADDR_W) begin : g_bad_gran
        $error("erg_snoop: GRAN_LSB out of range");
    end

    // ----------------------------------------------------------------
    // Reservation entry, one per tracked master
    // ----------------------------------------------------------------
    logic res_ff, nxt_res;
    logic [ADDR_W-1:0] raddr_ff, nxt_raddr;
    logic pend_ff, nxt_pend, sc_ff, nxt_sc, wr_ff, nxt_wr;
    logic [ADDR_W-1:0] paddr_ff, nxt_paddr;
    logic ack_n_ff, nxt_ack_n, rty_n_ff, nxt_rty_n, bg_n_ff, nxt_bg_n;
    logic mw_ff, nxt_mw;
    logic [ADDR_W-1:0] ma_ff, nxt_ma;
    logic other_hit;

    assign other_hit = other_store_i &&
        (other_addr_i[ADDR_W-1:GRAN_LSB] == raddr_ff[ADDR_W-1:GRAN_LSB]);

    // Tracking and cycle answering
    always_comb
    begin
        nxt_res = res_ff;
        nxt_raddr = raddr_ff;
        nxt_pend = pend_ff;
        nxt_sc = sc_ff;
        nxt_wr = wr_ff;
        nxt_paddr = paddr_ff;
        nxt_ack_n = 1'b1;
        nxt_rty_n = 1'b1;
        nxt_bg_n = link.bus_request_n;
        nxt_mw = 1'b0;
        nxt_ma = ma_ff;
        // Every transfer start is watched
        if (!link.transfer_start_n)
        begin
            nxt_pend = 1'b1;
            nxt_sc = link.store_cond;
            nxt_wr = link.write;
            nxt_paddr = link.addr;
            if (link.load_res)
            begin
                nxt_res = 1'b1;
                nxt_raddr = link.addr;
            end
            // Own plain stores leave the entry alone
        end
        if (pend_ff)
        begin
            nxt_pend = 1'b0;
            if (sc_ff && remote_lost_i)
            begin
                // Retry, drop status, hold grant off
                nxt_rty_n = 1'b0;
                nxt_res = 1'b0;
                nxt_bg_n = 1'b1;
            end
            else if (sc_ff && !remote_ready_i)
            begin
                nxt_pend = 1'b1;
            end
            else
            begin
                nxt_ack_n = 1'b0;
                // No store-conditional write once the reservation is gone; plain stores still write
                nxt_mw = wr_ff && !(sc_ff && !res_ff);
                nxt_ma = paddr_ff;
                if (sc_ff)
                begin
                    nxt_res = 1'b0;
                end
            end
        end
        if (other_hit)
        begin
            nxt_res = 1'b0;
        end
    end

    // Registered so status settles before the next start
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            res_ff <= 1'b0;
            raddr_ff <= '0;
            pend_ff <= 1'b0;
            sc_ff <= 1'b0;
            wr_ff <= 1'b0;
            paddr_ff <= '0;
            ack_n_ff <= 1'b1;
            rty_n_ff <= 1'b1;
            bg_n_ff <= 1'b1;
            mw_ff <= 1'b0;
            ma_ff <= '0;
        end
        else
        begin
            res_ff <= nxt_res;
            raddr_ff <= nxt_raddr;
            pend_ff <= nxt_pend;
            sc_ff <= nxt_sc;
            wr_ff <= nxt_wr;
            paddr_ff <= nxt_paddr;
            ack_n_ff <= nxt_ack_n;
            rty_n_ff <= nxt_rty_n;
            bg_n_ff <= nxt_bg_n;
            mw_ff <= nxt_mw;
            ma_ff <= nxt_ma;
        end
    end

    // Low means no reservation held
    assign link.cancel_reservation_n = res_ff;
    assign link.address_ack_n = ack_n_ff;
    assign link.address_retry_n = rty_n_ff;
    assign link.bus_grant_n = bg_n_ff;
    assign link.write_commit = mw_ff;
    assign mem_write_o = mw_ff;
    assign mem_addr_o = ma_ff;
endmodule : erg_snoop
`default_nettype wire
